// ### psrc_host_model.sv
// Register master model standing in for the host processor.
module psrc_host_model
    import psrc_pkg::*;
(
    // Clock
    input wire logic clock_i,
    // Register bus
    output psrc_reg_req_s reg_req_o,
    input wire logic [7:0] reg_rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;

    initial reg_req_o = '0;

    // Idle address and data toggle so a stale value is never mistaken.
    task automatic idle();
        reg_req_o.wr = 1'b0;
        reg_req_o.rd = 1'b0;
        reg_req_o.addr = ~reg_req_o.addr;
        reg_req_o.wdata = ~reg_req_o.wdata;
    endtask

    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        reg_req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clock_i);
        idle();
    endtask

    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock_i);
        reg_req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clock_i);
        // Read data stands for one cycle only, so take it before idling.
        d = reg_rdata_i;
        idle();
    endtask
endmodule

// ### psrc_pkg.sv
// Package of constants and types for the power state and reset control block.
// Behaviour
// - Any reset loads register defaults and opens every analog switch path.
// - After reset or power-up the device waits in standby for accessories.
// - Power-on reset comes from each rising edge of battery or bus supply.
// - Host writes reset bit at 1BH; device performs full hardware-style reset.
// - Reset and enable logic work for any supply arrival order.
// - Detection, switching and regulator enabled only while battery is valid.
// - Charging enabled whenever bus supply is valid, battery or not.
// - Register interface and interrupt work only with io and battery valid.
// - Host selects manual or automatic control of data-path switches.
// - Factory cable routes connector data to UART or USB path as needed.
package psrc_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] PSRC_ADDR_CONTROL = 8'h02;
    localparam logic [7:0] PSRC_ADDR_MANUAL_SW = 8'h13;
    localparam logic [7:0] PSRC_ADDR_SOFT_RESET = 8'h1B;
    localparam int PSRC_CTRL_AUTO_BIT = 2;
    localparam int PSRC_SOFT_RESET_BIT = 0;
    localparam logic [7:0] PSRC_CONTROL_RST = 8'h1F;
    localparam logic [7:0] PSRC_MANUAL_SW_RST = 8'h00;
    localparam logic [7:0] PSRC_SOFT_RESET_RST = 8'h00;
    localparam logic [1:0] PSRC_PATH_OPEN = 2'h0;
    localparam logic [1:0] PSRC_PATH_USB = 2'h1;
    localparam logic [1:0] PSRC_PATH_UART = 2'h2;
    localparam int PSRC_MAN_PATH_LSB = 0;
    localparam int PSRC_MAN_PATH_MSB = 1;
    localparam int PSRC_RESET_CYCLES = 4;
    localparam logic [2:0] PSRC_RESET_LAST = 3'(PSRC_RESET_CYCLES - 1);

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PSRC_FACT_NONE,
        PSRC_FACT_USB,
        PSRC_FACT_UART
    } psrc_factory_e;

    typedef enum {
        PSRC_ST_RESET,
        PSRC_ST_STANDBY
    } psrc_state_e;

    typedef struct packed {
        logic bat_valid;
        logic bus_valid;
        logic io_valid;
    } psrc_supply_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } psrc_reg_req_s;

    typedef struct packed {
        logic comm_en;
        logic detect_en;
        logic charge_en;
        logic ldo_en;
    } psrc_enable_s;
endpackage

// ### psrc_top.sv
// Power state decode, power-on and software reset, and data-path switch select.
module psrc_top
    import psrc_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // Supply comparators, asynchronous
    input wire psrc_supply_s supply_i,
    // Register access from the serial slave, same clock
    input wire psrc_reg_req_s reg_req_i,
    // Factory cable decode from detection, same clock
    input wire psrc_factory_e factory_i,
    // Outputs
    output psrc_enable_s enable_o,
    output logic [7:0] reg_rdata_o,
    output logic [1:0] switch_path_o,
    output logic standby_o,
    output logic dev_reset_o
);
    // ------------------------------------------------------------------
    // Supply synchronisers
    // ------------------------------------------------------------------
    psrc_supply_s sup_meta_r, sup_r, sup_prev_r;
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            sup_meta_r <= '0;
            sup_r <= '0;
            sup_prev_r <= '0;
        end else begin
            sup_meta_r <= supply_i;
            sup_r <= sup_meta_r;
            sup_prev_r <= sup_r;
        end
    end

    // Either main supply rising fires the power-on reset, in any order.
    logic por_evt;
    assign por_evt = (sup_r.bat_valid & ~sup_prev_r.bat_valid) |
                     (sup_r.bus_valid & ~sup_prev_r.bus_valid);

    logic comm_ok;
    assign comm_ok = sup_r.io_valid & sup_r.bat_valid;

    // ------------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------------
    psrc_state_e state_r, state_nxt;
    logic [2:0] rcnt_r, rcnt_nxt;
    logic soft_rst_req;
    assign soft_rst_req = comm_ok & reg_req_i.wr &
        (reg_req_i.addr == PSRC_ADDR_SOFT_RESET) &
        reg_req_i.wdata[PSRC_SOFT_RESET_BIT];

    always_comb begin
        state_nxt = state_r;
        rcnt_nxt = rcnt_r;
        case (state_r)
            PSRC_ST_RESET: begin
                if (rcnt_r == PSRC_RESET_LAST) begin
                    state_nxt = PSRC_ST_STANDBY;
                end else begin
                    rcnt_nxt = rcnt_r + 3'h1;
                end
            end
            PSRC_ST_STANDBY: begin
                if (por_evt || soft_rst_req) begin
                    state_nxt = PSRC_ST_RESET;
                    rcnt_nxt = 3'h0;
                end
            end
            default: begin
                state_nxt = PSRC_ST_RESET;
                rcnt_nxt = 3'h0;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state_r <= PSRC_ST_RESET;
            rcnt_r <= 3'h0;
        end else begin
            state_r <= state_nxt;
            rcnt_r <= rcnt_nxt;
        end
    end

    logic in_reset;
    assign in_reset = (state_nxt == PSRC_ST_RESET);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // The soft reset register never holds a one: a write to 1BH is not
    // stored in it, it only starts the reset, which reloads the default.
    logic [7:0] control_r, control_nxt;
    logic [7:0] manual_r, manual_nxt;
    logic [7:0] soft_r, soft_nxt;
    logic [7:0] rdata_nxt;
    always_comb begin
        control_nxt = control_r;
        manual_nxt = manual_r;
        soft_nxt = soft_r;
        rdata_nxt = 8'h00;
        if (in_reset) begin
            control_nxt = PSRC_CONTROL_RST;
            manual_nxt = PSRC_MANUAL_SW_RST;
            soft_nxt = PSRC_SOFT_RESET_RST;
        end else if (comm_ok && reg_req_i.wr) begin
            case (reg_req_i.addr)
                PSRC_ADDR_CONTROL: control_nxt = reg_req_i.wdata;
                PSRC_ADDR_MANUAL_SW: manual_nxt = reg_req_i.wdata;
                default: begin
                end
            endcase
        end
        if (comm_ok && reg_req_i.rd) begin
            case (reg_req_i.addr)
                PSRC_ADDR_CONTROL: rdata_nxt = control_r;
                PSRC_ADDR_MANUAL_SW: rdata_nxt = manual_r;
                PSRC_ADDR_SOFT_RESET: rdata_nxt = soft_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Switch path and enables
    // ------------------------------------------------------------------
    logic [1:0] path_nxt;
    psrc_enable_s en_nxt;
    always_comb begin
        path_nxt = PSRC_PATH_OPEN;
        en_nxt.detect_en = sup_r.bat_valid;
        en_nxt.ldo_en = sup_r.bat_valid;
        en_nxt.charge_en = sup_r.bus_valid;
        en_nxt.comm_en = comm_ok;
        if (in_reset || !sup_r.bat_valid) begin
            path_nxt = PSRC_PATH_OPEN;
        end else if (factory_i == PSRC_FACT_UART) begin
            path_nxt = PSRC_PATH_UART;
        end else if (factory_i == PSRC_FACT_USB) begin
            path_nxt = PSRC_PATH_USB;
        end else if (!control_r[PSRC_CTRL_AUTO_BIT]) begin
            path_nxt = manual_r[PSRC_MAN_PATH_MSB:PSRC_MAN_PATH_LSB];
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            control_r <= PSRC_CONTROL_RST;
            manual_r <= PSRC_MANUAL_SW_RST;
            soft_r <= PSRC_SOFT_RESET_RST;
            reg_rdata_o <= 8'h00;
            switch_path_o <= PSRC_PATH_OPEN;
            enable_o <= '0;
            standby_o <= 1'b0;
            dev_reset_o <= 1'b1;
        end else begin
            control_r <= control_nxt;
            manual_r <= manual_nxt;
            soft_r <= soft_nxt;
            reg_rdata_o <= rdata_nxt;
            switch_path_o <= path_nxt;
            enable_o <= en_nxt;
            standby_o <= ~in_reset;
            dev_reset_o <= in_reset;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_reset_opens: assert property (
        @(posedge clock_i) disable iff (srst_i)
        dev_reset_o |-> switch_path_o == PSRC_PATH_OPEN)
        else $error("switch path not open during reset");
    a_reset_defaults: assert property (
        @(posedge clock_i) disable iff (srst_i)
        dev_reset_o |-> control_r == PSRC_CONTROL_RST &&
        manual_r == PSRC_MANUAL_SW_RST)
        else $error("registers not at defaults during reset");
    a_standby_after: assert property (
        @(posedge clock_i) disable iff (srst_i)
        $rose(dev_reset_o) |-> ##[1:6] standby_o)
        else $error("standby not reached after reset");
    a_por_edge: assert property (
        @(posedge clock_i) disable iff (srst_i)
        (state_r == PSRC_ST_STANDBY && por_evt) |=> dev_reset_o)
        else $error("supply rise did not reset");
    a_soft_reset: assert property (
        @(posedge clock_i) disable iff (srst_i)
        (state_r == PSRC_ST_STANDBY && soft_rst_req) |=> dev_reset_o)
        else $error("soft reset write ignored");
    a_detect_bat: assert property (
        @(posedge clock_i) disable iff (srst_i)
        enable_o.detect_en == $past(sup_r.bat_valid))
        else $error("detect enable does not follow battery");
    a_charge_bus: assert property (
        @(posedge clock_i) disable iff (srst_i)
        sup_r.bus_valid |=> enable_o.charge_en)
        else $error("charging not enabled with bus supply");
    a_comm_gate: assert property (
        @(posedge clock_i) disable iff (srst_i)
        enable_o.comm_en |-> $past(sup_r.io_valid) && $past(sup_r.bat_valid))
        else $error("comm enabled without both supplies");
    a_factory_uart: assert property (
        @(posedge clock_i) disable iff (srst_i)
        (factory_i == PSRC_FACT_UART && sup_r.bat_valid && !in_reset)
        |=> switch_path_o == PSRC_PATH_UART)
        else $error("factory uart path not routed");
    a_soft_clears: assert property (
        @(posedge clock_i) disable iff (srst_i)
        soft_r[PSRC_SOFT_RESET_BIT] == 1'b0)
        else $error("soft reset bit stuck");
    c_por: cover property (@(posedge clock_i) por_evt ##1 dev_reset_o);
    c_soft: cover property (@(posedge clock_i) soft_rst_req ##1 dev_reset_o);
    c_uart: cover property (@(posedge clock_i)
        switch_path_o == PSRC_PATH_UART);
    c_manual: cover property (@(posedge clock_i)
        !control_r[PSRC_CTRL_AUTO_BIT] && switch_path_o == PSRC_PATH_USB);
endmodule

// ### test_power_state_and_reset_control.sv
// Self-checking bench for power state decode and reset sequencing.
module test_power_state_and_reset_control
    import psrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    psrc_supply_s supply_i = 3'h7;
    psrc_factory_e factory_i = PSRC_FACT_NONE;
    psrc_reg_req_s reg_req;
    psrc_enable_s enable_o;
    logic [7:0] reg_rdata_o;
    logic [1:0] switch_path_o;
    logic standby_o;
    logic dev_reset_o;
    logic [7:0] rd;
    int err_count = 0;
    int n_tests = 0;

    always #2 clock_i = ~clock_i;

    psrc_top i_psrc_top (.clock_i(clock_i), .srst_i(srst_i),
        .supply_i(supply_i), .reg_req_i(reg_req), .factory_i(factory_i),
        .enable_o(enable_o), .reg_rdata_o(reg_rdata_o),
        .switch_path_o(switch_path_o), .standby_o(standby_o),
        .dev_reset_o(dev_reset_o));
    psrc_host_model i_psrc_host_model (.clock_i(clock_i),
        .reg_req_o(reg_req), .reg_rdata_i(reg_rdata_o));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] g, input logic [7:0] e,
        input string m);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic stop_test();
        $display("Mismatches %0d, checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Waits for standby (sel 0) or internal reset (sel 1), 20 cycles max.
    task automatic wait_for(input bit sel);
        for (int i = 0; i < 20; i++) begin
            @(negedge clock_i);
            if ((sel ? dev_reset_o : standby_o) === 1'b1) return;
        end
        chk(8'h00, 8'h01, "wait bound used up");
        stop_test();
    endtask

    task automatic path_is(input logic [1:0] e, input string m);
        repeat (2) @(negedge clock_i);
        chk({6'h00, switch_path_o}, {6'h00, e}, m);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        chk({4'h0, enable_o}, 8'h00, "enables in reset");
        chk({6'h00, standby_o, dev_reset_o}, 8'h01, "reset out");
        path_is(PSRC_PATH_OPEN, "path in reset");
        srst_i = 1'b0;
        wait_for(1'b0);
        i_psrc_host_model.read(PSRC_ADDR_CONTROL, rd);
        chk(rd, PSRC_CONTROL_RST, "control default");
    endtask

    task automatic t_switch();
        i_psrc_host_model.write(PSRC_ADDR_CONTROL, 8'h1B);
        i_psrc_host_model.write(PSRC_ADDR_MANUAL_SW, 8'h02);
        path_is(PSRC_PATH_UART, "manual path");
        i_psrc_host_model.write(PSRC_ADDR_CONTROL, PSRC_CONTROL_RST);
        path_is(PSRC_PATH_OPEN, "auto path");
        factory_i = PSRC_FACT_USB;
        path_is(PSRC_PATH_USB, "factory usb");
        factory_i = PSRC_FACT_UART;
        path_is(PSRC_PATH_UART, "factory uart");
        factory_i = PSRC_FACT_NONE;
    endtask

    task automatic t_soft();
        i_psrc_host_model.write(PSRC_ADDR_CONTROL, 8'h1B);
        i_psrc_host_model.write(PSRC_ADDR_MANUAL_SW, 8'h01);
        path_is(PSRC_PATH_USB, "manual usb");
        i_psrc_host_model.write(PSRC_ADDR_SOFT_RESET, 8'h01);
        chk({7'h00, dev_reset_o}, 8'h01, "soft reset");
        chk({6'h00, switch_path_o}, 8'h00, "path opened");
        wait_for(1'b0);
        i_psrc_host_model.read(PSRC_ADDR_CONTROL, rd);
        chk(rd, PSRC_CONTROL_RST, "control restored");
        i_psrc_host_model.read(PSRC_ADDR_SOFT_RESET, rd);
        chk(rd, PSRC_SOFT_RESET_RST, "reset bit");
    endtask

    // Every supply pattern in rising order, so arrival orders vary.
    task automatic t_enables();
        logic [2:0] s;
        logic [7:0] e;
        for (int k = 0; k < 8; k++) begin
            s = 3'(k);
            supply_i = s;
            repeat (12) @(negedge clock_i);
            e = {4'h0, s[2] & s[0], s[2], s[1], s[2]};
            chk({4'h0, enable_o}, e, "enables");
        end
        supply_i = 3'h4;
        repeat (6) @(negedge clock_i);
        i_psrc_host_model.write(PSRC_ADDR_CONTROL, 8'h00);
        supply_i = 3'h5;
        repeat (6) @(negedge clock_i);
        i_psrc_host_model.read(PSRC_ADDR_CONTROL, rd);
        chk(rd, PSRC_CONTROL_RST, "write without io");
    endtask

    task automatic t_por();
        srst_i = 1'b1;
        supply_i = 3'h0;
        repeat (12) @(negedge clock_i);
        srst_i = 1'b0;
        wait_for(1'b0);
        supply_i = 3'h2;
        wait_for(1'b1);
        wait_for(1'b0);
        chk({4'h0, enable_o}, 8'h02, "charge only");
        factory_i = PSRC_FACT_UART;
        path_is(PSRC_PATH_OPEN, "no battery path");
    endtask

    initial begin
        repeat (12) @(negedge clock_i);
        t_reset();
        t_switch();
        t_soft();
        t_enables();
        t_por();
        stop_test();
    end
endmodule
